// ---- eeacc_pkg.sv ----
// Purpose: Constants and types for the serial EEPROM array access block
// Assumes: 125 MHz core clock; SPI pins are sampled in the core clock domain
// Notes:   Shared by eeacc_array, eeacc_timer, eeacc_array_chk and eeacc_array_tb
//
// What this block does
// - Opcode 03h starts an array read, 02h an array write, first byte after select.
// - Array address is sixteen bits, bit 15 down to bit 0, after the opcode.
// - Read loads the address register and shifts out the byte stored there.
// - While select stays low, address increments after each byte, no byte limit.
// - Read address wraps from top of array to zero and continues.
// - Raising select at any point ends the read and stops output drive.
// - Read opcode is ignored while a program cycle runs.
// - Select rising right after a whole data byte starts the fixed program cycle.
// - Busy flag is one during the program cycle, zero when it ends.
// - Write data bumps only in-page address bits; whole page programs in one cycle.
// - Page is 128 bytes; overrun wraps to page start and overwrites buffered bytes.
// - Write refused if latch clear, cycle running, deselected early, or page guarded.
// - Write-enable latch clears when a write completes.
// - Guard bits: 00 none, 01 C000h-FFFFh, 10 8000h-FFFFh, 11 whole array.
// - In every mode, writes inside guarded range refused, outside accepted.
// - With status lock zero, status writes accepted when the latch is set and no program cycle runs.
// - Status lock bit starts at zero.
// - Lock one and protect pin high: status writes still accepted with latch set.
// - Lock one and protect pin low: every status write refused.
// - Hard lock mode holds whenever lock is one and protect pin low.
// - Hard lock mode is left when the protect pin goes high, or when a status write begun before the pin fell clears lock.

package eeacc_pkg;

    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned ARRAY_BYTES = 65536;
    localparam int unsigned PAGE_BYTES  = 128;
    localparam int unsigned PAGE_W      = 7;

    // ************************************************************
    // Opcodes and guard decode
    // ************************************************************
    localparam logic [7:0]  OPC_READ   = 8'h03;
    localparam logic [7:0]  OPC_WRITE  = 8'h02;
    localparam logic [1:0]  GUARD_NONE = 2'h0;
    localparam logic [1:0]  GUARD_QTR  = 2'h1;
    localparam logic [1:0]  GUARD_HALF = 2'h2;
    localparam logic [15:0] QTR_BASE   = 16'hC000;
    localparam logic [15:0] HALF_BASE  = 16'h8000;

    // ************************************************************
    // Status write data field positions and reset values
    // ************************************************************
    localparam int unsigned SW_LOCK_POS = 2;
    localparam int unsigned SW_HI_POS   = 1;
    localparam int unsigned SW_LO_POS   = 0;
    localparam logic        LOCK_RST    = 1'b0;
    localparam logic [1:0]  GUARD_RST   = 2'h0;
    localparam logic        WEL_RST     = 1'b0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned PROG_TIME_NS  = 5000000;
    localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Serial command state
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_OPC    = 6'h02,
        ST_ADDR   = 6'h04,
        ST_RDATA  = 6'h08,
        ST_WDATA  = 6'h10,
        ST_IGNORE = 6'h20
    } eeacc_state_t;

endpackage

// ---- eeacc_fifo2.sv ----
// Purpose: Small valid/ready buffer for read data
// Assumes: DEPTH is a power of two, at least two
// Notes:   Flush empties it at once
`timescale 1ns/1ps
`default_nettype none

module eeacc_fifo2 #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("eeacc_fifo2: DEPTH must be a power of two, at least two");
    end

    logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    wire  logic       push;
    wire  logic       pop;

    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign in_ready  = ~((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                         (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_data  = buf_mem[rd_ptr_reg[AW-1:0]];
    assign push      = in_valid & in_ready & ~flush;
    assign pop       = out_valid & out_ready & ~flush;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

endmodule // eeacc_fifo2

`default_nettype wire

// ---- eeacc_timer.sv ----
// Purpose: Self-timed program cycle counter
// Assumes: start is ignored while busy
// Notes:   done is high in the last busy cycle
`timescale 1ns/1ps
`default_nettype none

module eeacc_timer #(
    parameter int unsigned CYCLES = eeacc_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    if (CYCLES < 2) begin : g_bad_cycles
        $error("eeacc_timer: CYCLES must be at least two");
    end

    logic [CW-1:0] cnt_reg;

    assign done = busy & (cnt_reg == '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy    <= 1'b0;
            cnt_reg <= '0;
        end else if (start & ~busy) begin
            busy    <= 1'b1;
            cnt_reg <= CW'(CYCLES - 1);
        end else if (done) begin
            busy    <= 1'b0;
        end else if (busy) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

endmodule // eeacc_timer

`default_nettype wire

// ---- eeacc_array.sv ----
// Purpose: Array read/write and write protection of a 64 KiB SPI EEPROM
// Assumes: SPI mode 0 or 3; SPI clock well below a quarter of core_clk
// Notes:   Array and page buffer are held in this module
`timescale 1ns/1ps
`default_nettype none

module eeacc_array #(
    parameter int unsigned PROG_CYCLES = eeacc_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // SPI pins
    input  wire logic       spi_clk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    // Protect pin
    input  wire logic       protect_n,
    // Latch and status write requests
    input  wire logic       arm_write_req,
    input  wire logic       status_wr_req,
    input  wire logic [2:0] status_wr_data,
    // Status
    output logic            program_busy_flag,
    output logic            write_enable_latch,
    output logic            block_guard_hi,
    output logic            block_guard_lo,
    output logic            status_lock_bit,
    output logic            hard_lock_mode,
    output logic            soft_guard_mode
);
    import eeacc_pkg::*;

    if (PROG_CYCLES <= PAGE_BYTES + 1) begin : g_bad_prog
        $error("eeacc_array: PROG_CYCLES too short to copy one page");
    end

    localparam logic [7:0] PAGE_END = 8'h80;

    // ************************************************************
    // Guard decode
    // ************************************************************
    function automatic logic page_guarded(input logic [1:0]  g,
                                          input logic [15:0] a);
        logic r;
        r = 1'b0;
        case (g)
            GUARD_NONE: r = 1'b0;
            GUARD_QTR:  r = (a >= QTR_BASE);
            GUARD_HALF: r = (a >= HALF_BASE);
            default:    r = 1'b1;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0]            mem_array [0:ARRAY_BYTES-1];
    logic [7:0]            page_buf  [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] page_valid_reg;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic       sclk_prev_reg;
    logic       cs_prev_reg;
    wire  logic sclk_s;
    wire  logic cs_s;
    wire  logic mosi_s;
    wire  logic prot_s;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1_reg    <= 4'h6;
            pin_s2_reg    <= 4'h6;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
        end else begin
            pin_s1_reg    <= {spi_clk, spi_cs_n, spi_mosi, protect_n};
            pin_s2_reg    <= pin_s1_reg;
            sclk_prev_reg <= sclk_s;
            cs_prev_reg   <= cs_s;
        end
    end

    assign {sclk_s, cs_s, mosi_s, prot_s} = pin_s2_reg;

    // ************************************************************
    // Registers
    // ************************************************************
    eeacc_state_t    state_reg;
    logic [7:0]      rx_shift_reg;
    logic [2:0]      rx_cnt_reg;
    logic            addr_byte_reg;
    logic            is_read_reg;
    logic [15:0]     addr_reg;
    logic [15:0]     rd_addr_reg;
    logic [8:0]      wr_page_reg;
    logic [PAGE_W-1:0] wr_off_reg;
    logic            wr_any_reg;
    logic [6:0]      tx_shift_reg;
    logic [2:0]      tx_cnt_reg;
    logic [7:0]      copy_idx_reg;
    logic            prog_array_reg;
    logic [2:0]      pend_status_reg;
    logic [1:0]      guard_reg;
    logic            lock_reg;

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic        rise;
    wire logic        fall;
    wire logic        cs_rise;
    wire logic [7:0]  rx_byte;
    wire logic        byte_done;
    wire logic [15:0] addr_next;
    wire logic        addr_done;
    wire logic        hard_lock;
    wire logic        wr_allowed;
    wire logic        busy;
    wire logic        prog_done;
    wire logic        prog_start;
    wire logic        st_start;
    wire logic        copy_run;
    wire logic        copy_we;
    wire logic        fifo_in_valid;
    wire logic        fifo_in_ready;
    wire logic        fifo_out_valid;
    wire logic        fifo_out_ready;
    wire logic [7:0]  fifo_out_data;
    wire logic        tx_load;

    assign rise       = sclk_s & ~sclk_prev_reg & ~cs_s;
    assign fall       = ~sclk_s & sclk_prev_reg & ~cs_s;
    assign cs_rise    = cs_s & ~cs_prev_reg;
    assign rx_byte    = {rx_shift_reg[6:0], mosi_s};
    assign byte_done  = rise & (rx_cnt_reg == 3'h7);
    assign addr_next  = {addr_reg[7:0], rx_byte};
    assign addr_done  = byte_done & (state_reg == ST_ADDR) & addr_byte_reg;
    assign hard_lock  = lock_reg & ~prot_s;
    assign wr_allowed = write_enable_latch & ~busy &
                        ~page_guarded(guard_reg, addr_next);
    assign prog_start = cs_rise & (state_reg == ST_WDATA) &
                        (rx_cnt_reg == 3'h0) & wr_any_reg & ~busy;
    assign st_start   = status_wr_req & write_enable_latch & ~hard_lock &
                        ~busy & ~prog_start;
    assign copy_run   = busy & (copy_idx_reg < PAGE_END);
    assign copy_we    = copy_run & prog_array_reg &
                        page_valid_reg[copy_idx_reg[PAGE_W-1:0]];
    assign fifo_in_valid  = (state_reg == ST_RDATA) & ~cs_s;
    assign tx_load        = fall & (state_reg == ST_RDATA) & (tx_cnt_reg == 3'h0);
    assign fifo_out_ready = tx_load;

    // ************************************************************
    // Program cycle timer and read buffer
    // ************************************************************
    eeacc_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk   (core_clk),
        .rst   (rst),
        .start (prog_start | st_start),
        .busy  (busy),
        .done  (prog_done)
    );

    eeacc_fifo2 #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_rd_buf (
        .clk       (core_clk),
        .rst       (rst),
        .flush     (cs_s),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_array[rd_addr_reg]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign program_busy_flag = busy;

    // ************************************************************
    // Command sequencer
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            rx_shift_reg  <= 8'h00;
            rx_cnt_reg    <= 3'h0;
            addr_byte_reg <= 1'b0;
            is_read_reg   <= 1'b0;
            addr_reg      <= 16'h0000;
        end else if (cs_s) begin
            state_reg     <= ST_IDLE;
            rx_cnt_reg    <= 3'h0;
            addr_byte_reg <= 1'b0;
        end else begin
            if (rise) begin
                rx_shift_reg <= rx_byte;
                rx_cnt_reg   <= rx_cnt_reg + 3'h1;
            end
            case (state_reg)
                ST_IDLE, ST_OPC: begin
                    state_reg <= ST_OPC;
                    if (byte_done) begin
                        is_read_reg <= (rx_byte == OPC_READ);
                        if ((rx_byte == OPC_READ && !busy) || rx_byte == OPC_WRITE) begin
                            state_reg <= ST_ADDR;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        addr_reg      <= addr_next;
                        addr_byte_reg <= 1'b1;
                        if (addr_byte_reg) begin
                            if (is_read_reg) begin
                                state_reg <= ST_RDATA;
                            end else if (wr_allowed) begin
                                state_reg <= ST_WDATA;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end
                    end
                end
                ST_RDATA, ST_WDATA, ST_IGNORE: begin
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= ST_IGNORE;
                end
            endcase
        end
    end

    // ************************************************************
    // Read address and serial output
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_addr_reg <= 16'h0000;
        end else if (addr_done) begin
            rd_addr_reg <= addr_next;
        end else if (fifo_in_valid & fifo_in_ready) begin
            rd_addr_reg <= rd_addr_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spi_miso     <= 1'b0;
            spi_miso_oe  <= 1'b0;
            tx_shift_reg <= 7'h00;
            tx_cnt_reg   <= 3'h0;
        end else begin
            spi_miso_oe <= (state_reg == ST_RDATA) & ~cs_s;
            if (cs_s) begin
                spi_miso   <= 1'b0;
                tx_cnt_reg <= 3'h0;
            end else if (tx_load & fifo_out_valid) begin
                spi_miso     <= fifo_out_data[7];
                tx_shift_reg <= fifo_out_data[6:0];
                tx_cnt_reg   <= 3'h7;
            end else if (fall & (tx_cnt_reg != 3'h0)) begin
                spi_miso     <= tx_shift_reg[6];
                tx_shift_reg <= {tx_shift_reg[5:0], 1'b0};
                tx_cnt_reg   <= tx_cnt_reg - 3'h1;
            end
        end
    end

    // ************************************************************
    // Page loading
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_page_reg    <= 9'h000;
            wr_off_reg     <= '0;
            wr_any_reg     <= 1'b0;
            page_valid_reg <= '0;
        end else if (addr_done & ~is_read_reg & wr_allowed) begin
            wr_page_reg    <= addr_next[15:7];
            wr_off_reg     <= addr_next[PAGE_W-1:0];
            wr_any_reg     <= 1'b0;
            page_valid_reg <= '0;
        end else if (byte_done & (state_reg == ST_WDATA)) begin
            wr_off_reg                 <= wr_off_reg + 1'b1;
            wr_any_reg                 <= 1'b1;
            page_valid_reg[wr_off_reg] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (byte_done & (state_reg == ST_WDATA)) begin
            page_buf[wr_off_reg] <= rx_byte;
        end
        if (copy_we) begin
            mem_array[{wr_page_reg, copy_idx_reg[PAGE_W-1:0]}] <=
                page_buf[copy_idx_reg[PAGE_W-1:0]];
        end
    end

    // ************************************************************
    // Program cycle, latch and status bits
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            copy_idx_reg    <= 8'h00;
            prog_array_reg  <= 1'b0;
            pend_status_reg <= 3'h0;
        end else if (prog_start | st_start) begin
            copy_idx_reg    <= 8'h00;
            prog_array_reg  <= prog_start;
            pend_status_reg <= status_wr_data;
        end else if (copy_run) begin
            copy_idx_reg    <= copy_idx_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= WEL_RST;
            guard_reg          <= GUARD_RST;
            lock_reg           <= LOCK_RST;
        end else begin
            if (prog_done) begin
                write_enable_latch <= 1'b0;
                if (!prog_array_reg) begin
                    lock_reg  <= pend_status_reg[SW_LOCK_POS];
                    guard_reg <= {pend_status_reg[SW_HI_POS], pend_status_reg[SW_LO_POS]};
                end
            end else if (arm_write_req & ~busy) begin
                write_enable_latch <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            block_guard_hi  <= 1'b0;
            block_guard_lo  <= 1'b0;
            status_lock_bit <= 1'b0;
            hard_lock_mode  <= 1'b0;
            soft_guard_mode <= 1'b1;
        end else begin
            block_guard_hi  <= guard_reg[1];
            block_guard_lo  <= guard_reg[0];
            status_lock_bit <= lock_reg;
            hard_lock_mode  <= hard_lock;
            soft_guard_mode <= ~hard_lock;
        end
    end

endmodule // eeacc_array

`default_nettype wire

// ---- eeacc_array_chk.sv ----
// Purpose: Port assertions for eeacc_array
// Assumes: One clock domain, rst asynchronous
// Notes:   Bound to every eeacc_array instance
`timescale 1ns/1ps
`default_nettype none
module eeacc_array_chk #(
    parameter int unsigned PROG_CYCLES = eeacc_pkg::PROG_CYCLES
) (
    // Clock, reset, pins and status
    input wire logic core_clk, rst, spi_cs_n, spi_miso_oe, protect_n,
    input wire logic program_busy_flag, write_enable_latch, block_guard_hi,
    input wire logic block_guard_lo, status_lock_bit, hard_lock_mode, soft_guard_mode
);
    logic [31:0] busy_cnt;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) busy_cnt <= '0;
        else busy_cnt <= program_busy_flag ? busy_cnt + 32'h1 : '0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_oe_off; spi_cs_n [*5] |-> !spi_miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven after deselect");
    property p_rd_busy; program_busy_flag |-> !spi_miso_oe; endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read served while busy");
    property p_modes; soft_guard_mode == !hard_lock_mode; endproperty
    a_modes: assert property (p_modes) else $error("mode flags disagree");
    property p_hard_on; (status_lock_bit && !protect_n) [*5] |-> hard_lock_mode; endproperty
    a_hard_on: assert property (p_hard_on) else $error("hard lock not entered");
    property p_hard_off; protect_n [*5] |-> !hard_lock_mode; endproperty
    a_hard_off: assert property (p_hard_off) else $error("hard lock not left");
    property p_frozen;
        hard_lock_mode [*2] |=> $stable({status_lock_bit, block_guard_hi, block_guard_lo});
    endproperty
    a_frozen: assert property (p_frozen) else $error("status changed in hard lock");
    property p_busy_len; $fell(program_busy_flag) |-> busy_cnt == PROG_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("program cycle length wrong");
    property p_wel_clr; $fell(program_busy_flag) |-> ##[0:2] !write_enable_latch; endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch kept after cycle");
    c_read: cover property ($rose(spi_miso_oe));
    c_prog: cover property ($rose(program_busy_flag));
    c_hard: cover property ($rose(hard_lock_mode));
endmodule // eeacc_array_chk
bind eeacc_array eeacc_array_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- eeacc_host.sv ----
// Purpose: SPI host model, mode 0, MSB first
// Assumes: Half SPI period of six core cycles
// Notes:   Data line toggles together with each select change
`timescale 1ns/1ps
`default_nettype none
module eeacc_host (
    // Pacing clock and SPI pins
    input  wire logic core_clk,
    output logic      spi_clk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial spi_clk = 1'b0;
    initial spi_cs_n = 1'b1;
    initial spi_mosi = 1'b0;
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic sel(input logic on);
        cyc(6);
        spi_cs_n = !on;
        spi_mosi = !spi_mosi;
        cyc(6);
    endtask
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = d[i];
            cyc(6);
            q[i] = spi_miso;
            spi_clk = 1'b1;
            cyc(6);
            spi_clk = 1'b0;
        end
    endtask
endmodule // eeacc_host
`default_nettype wire

// ---- eeacc_array_tb.sv ----
// Purpose: Self-checking bench for eeacc_array
// Assumes: Program cycle shortened to 200 core cycles
// Notes:   SPI traffic comes from eeacc_host
`timescale 1ns/1ps
`default_nettype none
module eeacc_array_tb;
    import eeacc_pkg::*;
    localparam int unsigned PC = 200;
    logic core_clk = 1'b0, rst = 1'b1, protect_n, arm_write_req, status_wr_req = 1'b0;
    logic [2:0] status_wr_data = 3'h0;
    logic [7:0] q, got [2];
    wire logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, program_busy_flag;
    wire logic write_enable_latch, block_guard_hi, block_guard_lo, status_lock_bit;
    wire logic hard_lock_mode, soft_guard_mode;
    int errors = 0, n_checks = 0;
    eeacc_array #(.PROG_CYCLES(PC)) uut (.*);
    eeacc_host host (.*, .spi_miso(spi_miso_oe ? spi_miso : 1'b1));
    initial forever #4 core_clk = ~core_clk;
    initial begin
        #400000 errors++;
        results();
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic req(input logic st, input logic [2:0] d);
        arm_write_req = 1'b1;
        host.cyc(1);
        arm_write_req = 1'b0;
        status_wr_data = d;
        host.cyc(3);
        status_wr_req = st;
        host.cyc(1);
        status_wr_req = 1'b0;
        host.cyc(2);
    endtask
    task automatic frame(input logic [7:0] op, input logic [15:0] a, input int n, input logic [7:0] b);
        host.sel(1'b1);
        host.xb(op, q);
        host.xb(a[15:8], q);
        host.xb(a[7:0], q);
        for (int i = 0; i < n; i++) host.xb(b + 8'(i), got[i & 1]);
        host.sel(1'b0);
    endtask
    task automatic fin(input logic ok);
        chk("busy", 16'(program_busy_flag), 16'(ok));
        for (int i = 0; i < PC + 9 && program_busy_flag !== 1'b0; i++) host.cyc(1);
        chk("idle", 16'(program_busy_flag), 16'h0);
        host.cyc(4);
    endtask
    task automatic t_rw();
        req(1'b0, 3'h0);
        frame(OPC_WRITE, 16'h7F7E, 4, 8'h10);
        fin(1'b1);
        chk("wel", 16'(write_enable_latch), 16'h0);
        frame(OPC_WRITE, 16'h2000, 1, 8'h40);
        fin(1'b0);
        frame(OPC_READ, 16'h7F7E, 2, 8'h00);
        chk("rd", {got[0], got[1]}, 16'h1011);
        frame(OPC_READ, 16'h7F00, 2, 8'h00);
        chk("rd_page", {got[0], got[1]}, 16'h1213);
    endtask
    task automatic t_wrap();
        req(1'b0, 3'h0);
        frame(OPC_WRITE, 16'hFFFF, 1, 8'h20);
        fin(1'b1);
        req(1'b0, 3'h0);
        frame(OPC_WRITE, 16'h0000, 1, 8'h22);
        fin(1'b1);
        frame(OPC_READ, 16'hFFFF, 2, 8'h00);
        chk("rd_wrap", {got[0], got[1]}, 16'h2022);
    endtask
    task automatic t_guard();
        logic [15:0] adr [3];
        adr = '{16'h0040, 16'h8040, 16'hC040};
        for (int g = 0; g < 4; g++) begin
            req(1'b1, 3'(g));
            fin(1'b1);
            chk("guard", 16'({block_guard_hi, block_guard_lo}), 16'(g));
            for (int k = 0; k < 3; k++) begin
                req(1'b0, 3'h0);
                frame(OPC_WRITE, adr[k], 1, 8'h30);
                fin(!(g == 3 || (g == 2 && k > 0) || (g == 1 && k == 2)));
            end
        end
    endtask
    task automatic t_lock();
        protect_n = 1'b0;
        req(1'b1, 3'h4);
        fin(1'b1);
        req(1'b1, 3'h1);
        fin(1'b0);
        chk("locked", 16'({block_guard_hi, block_guard_lo, status_lock_bit, hard_lock_mode}), 16'h3);
        protect_n = 1'b1;
        host.cyc(4);
        req(1'b1, 3'h5);
        frame(OPC_READ, 16'h7F7E, 2, 8'h00);
        chk("rd_busy", {got[0], got[1]}, 16'hFFFF);
        fin(1'b0);
        chk("soft", 16'({block_guard_hi, block_guard_lo, status_lock_bit, hard_lock_mode}), 16'h6);
        protect_n = 1'b0;
        host.cyc(6);
        chk("hard", 16'(hard_lock_mode), 16'h1);
        protect_n = 1'b1;
        host.cyc(6);
        req(1'b1, 3'h0);
        fin(1'b1);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        protect_n = 1'b1;
        arm_write_req = 1'b0;
        host.cyc(4);
        rst = 1'b0;
        host.cyc(6);
        chk("rst", 16'({status_lock_bit, program_busy_flag, write_enable_latch}), 16'h0);
        t_rw();
        t_wrap();
        t_guard();
        t_lock();
        results();
    end
endmodule // eeacc_array_tb
`default_nettype wire
